// ==== rtl/pbtdm_dma_regs.sv ====
// Purpose: Backend control port holding the DMA address and control
//          registers.
// Assumes: Strobes are synchronous and active low.
// Notes:   Reads are pipelined two cycles from index to data.
`timescale 1ns/1ps
`default_nettype none
module pbtdm_dma_regs (
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Backend control port
  input wire logic ctrl_select_n,
  input wire logic ctrl_read_strobe_n,
  input wire logic ctrl_write_strobe_n,
  input wire logic [pbtdm_pkg::IDX_W-1:0] ctrl_index,
  input wire logic [pbtdm_pkg::DATA_W-1:0] ctrl_wdata,
  output logic [pbtdm_pkg::DATA_W-1:0] ctrl_rdata,
  output logic ctrl_rdata_oe_n,
  // To the DMA engine
  input wire logic done_set,
  output logic [pbtdm_pkg::DATA_W-1:0] pci_start_addr,
  output logic [pbtdm_pkg::DATA_W-1:0] ram_start_addr,
  output logic [pbtdm_pkg::DATA_W-1:0] control,
  output logic go
);
  import pbtdm_pkg::*;

  logic [DATA_W-1:0] pci_addr_ff;
  logic [DATA_W-1:0] ram_addr_ff;
  logic [DATA_W-1:0] ctl_ff;
  logic done_ff;
  logic go_ff;
  logic [IDX_W-1:0] idx_ff;
  logic [DATA_W-1:0] rdata_ff;
  logic oe_n_ff;

  // ----------------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------------
  wire wr_en = !ctrl_select_n && !ctrl_write_strobe_n;
  wire wr_pci = wr_en && (ctrl_index == IDX_PCI_ADDR);
  wire wr_ram = wr_en && (ctrl_index == IDX_RAM_ADDR);
  wire wr_ctl = wr_en && (ctrl_index == IDX_CONTROL);
  wire nxt_go = wr_ctl && ctrl_wdata[CTL_GO0_BIT]
    && ctrl_wdata[CTL_GO1_BIT];
  wire nxt_done = done_set || (done_ff && !nxt_go);
  wire [DATA_W-1:0] ctl_view = {ctl_ff[DATA_W-1:CTL_DONE_BIT+1], done_ff,
    ctl_ff[CTL_DONE_BIT-1:0]};
  wire [DATA_W-1:0] nxt_rdata = (idx_ff == IDX_PCI_ADDR) ? pci_addr_ff :
    (idx_ff == IDX_RAM_ADDR) ? ram_addr_ff :
    (idx_ff == IDX_CONTROL) ? ctl_view : DATA_ZERO;
  wire nxt_oe_n = ctrl_select_n || ctrl_read_strobe_n;

  // ----------------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------------
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pci_addr_ff <= ADDR_RESET;
      ram_addr_ff <= ADDR_RESET;
      ctl_ff <= CTL_RESET;
      done_ff <= 1'b0;
      go_ff <= 1'b0;
      idx_ff <= IDX_PCI_ADDR;
      rdata_ff <= DATA_ZERO;
      oe_n_ff <= 1'b1;
    end else begin
      if (wr_pci) pci_addr_ff <= ctrl_wdata;
      if (wr_ram) ram_addr_ff <= ctrl_wdata;
      if (wr_ctl) ctl_ff <= ctrl_wdata;
      done_ff <= nxt_done;
      go_ff <= nxt_go;
      idx_ff <= ctrl_index;
      rdata_ff <= nxt_rdata;
      oe_n_ff <= nxt_oe_n;
    end
  end

  assign pci_start_addr = pci_addr_ff;
  assign ram_start_addr = ram_addr_ff;
  assign control = ctl_view;
  assign go = go_ff;
  assign ctrl_rdata = rdata_ff;
  assign ctrl_rdata_oe_n = oe_n_ff;

endmodule : pbtdm_dma_regs
`default_nettype wire

// ==== rtl/pbtdm_pkg.sv ====
// Purpose: Shared constants and types for the PCI backend termination and
//          DMA master block.
// Assumes: 32-bit PCI, one clock domain.
// Notes:   Register indices are those of the backend control port.
package pbtdm_pkg;

  // ----------------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------------
  localparam int DATA_W = 32;
  localparam int IDX_W = 2;
  localparam int LEN_W = 11;
  localparam int FILL_W = 2;

  // ----------------------------------------------------------------------
  // Register indices and fields
  // ----------------------------------------------------------------------
  localparam logic [1:0] IDX_PCI_ADDR = 2'h0;
  localparam logic [1:0] IDX_RAM_ADDR = 2'h1;
  localparam logic [1:0] IDX_CONTROL = 2'h2;
  localparam int CTL_DONE_BIT = 1;
  localparam int CTL_DIR_BIT = 3;
  localparam int CTL_GO0_BIT = 4;
  localparam int CTL_GO1_BIT = 5;
  localparam int CTL_LEN_LSB = 16;
  localparam int CTL_LEN_MSB = 27;
  localparam logic [31:0] CTL_RESET = 32'h0000_0000;
  localparam logic [31:0] ADDR_RESET = 32'h0000_0000;
  localparam logic [10:0] LEN_MAX = 11'h400;
  localparam logic [10:0] LEN_ONE = 11'h001;
  localparam logic [10:0] LEN_ZERO = 11'h000;

  // ----------------------------------------------------------------------
  // Bus codes and counts
  // ----------------------------------------------------------------------
  localparam logic [3:0] CMD_MEM_READ = 4'h6;
  localparam logic [3:0] CMD_MEM_WRITE = 4'h7;
  localparam logic [3:0] BE_ALL_N = 4'h0;
  localparam logic [31:0] ADDR_STEP = 32'h0000_0004;
  localparam logic [31:0] DATA_ZERO = 32'h0000_0000;
  localparam logic [1:0] PIPE_DEPTH = 2'h2;
  localparam logic [1:0] FILL_ONE = 2'h1;
  localparam logic [1:0] FILL_ZERO = 2'h0;
  localparam int DISC_TIMEOUT = 8;

  // ----------------------------------------------------------------------
  // State machines
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    T_IDLE, T_DATA, T_RETRY, T_ABORT, T_DISC
  } pbtdm_tstate_t;

  typedef enum logic [2:0] {
    M_IDLE, M_REQ, M_ADDR, M_DATA, M_TURN
  } pbtdm_mstate_t;

endpackage : pbtdm_pkg

// ==== rtl/pbtdm_top.sv ====
// Purpose: Backend termination control, backend arbitration, interrupt
//          forwarding and DMA master for a PCI interface.
// Assumes: All inputs but the async resetn synchronous to clock; outputs of two-way pins carry
//          an active-low output enable.
// Notes:
// Notes on behaviour
// - Backend error gives target abort, STOP with DEVSEL released.
// - Grant or busy at access start gives retry.
// - Retry drives STOP and DEVSEL, never TRDY.
// - Ready time-out gives disconnect without data.
// - Grant backend request once controller idle.
// - Hold grant; drop it cycle after release.
// - Interrupt sampled each edge, INTA next cycle.
// - Separate PCI and RAM addresses; bit3 direction.
// - Length bits 27-16, zero means 1024 DWORDs.
// - Bits 4 and 5 written one start DMA.
// - Completion sets control bit 1.
// - DMA read drives FRAME, address, command 0110.
// - Grant gives datapath_start; address with FRAME.
// - IRDY follows FRAME when backend ready.
// - Two-DWORD pipe; stop backend reads when full.
// - Burst ends at count or disconnect; FRAME high.
// - DMA write asserts IRDY once pipe filled.
// - Select plus write strobe writes; bursts allowed.
// - Read data two cycles on; drive one cycle behind strobes.
// - Ready withdrawn inserts TRDY wait states.
`timescale 1ns/1ps
`default_nettype none
module pbtdm_top #(
  parameter int TIMEOUT_CYC = pbtdm_pkg::DISC_TIMEOUT
) (
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Target access and backend status
  input wire logic access_start,
  input wire logic access_is_read,
  input wire logic backend_error,
  input wire logic backend_busy,
  input wire logic backend_read_ready,
  input wire logic backend_write_ready,
  // PCI control inputs
  input wire logic frame_n_in,
  input wire logic irdy_n_in,
  input wire logic trdy_n_in,
  input wire logic stop_n_in,
  input wire logic gnt_n,
  // Target control outputs
  output logic devsel_n_out,
  output logic trdy_n_out,
  output logic stop_n_out,
  output logic tgt_ctl_oe_n,
  // Backend arbitration
  input wire logic backend_request,
  output logic backend_grant,
  // Interrupt
  input wire logic external_interrupt_in,
  output logic inta_n_out,
  output logic inta_n_oe_n,
  // Master control outputs
  output logic req_n,
  output logic frame_n_out,
  output logic irdy_n_out,
  output logic mst_ctl_oe_n,
  output logic datapath_start,
  // Address and data
  input wire logic [pbtdm_pkg::DATA_W-1:0] ad_in,
  output logic [pbtdm_pkg::DATA_W-1:0] ad_out,
  output logic ad_oe_n,
  output logic [3:0] cbe_n_out,
  output logic cbe_n_oe_n,
  // Backend datapath
  output logic backend_read_strobe,
  input wire logic [pbtdm_pkg::DATA_W-1:0] backend_rdata,
  output logic backend_write_strobe,
  output logic [pbtdm_pkg::DATA_W-1:0] backend_wdata,
  output logic [pbtdm_pkg::DATA_W-1:0] backend_addr,
  // Backend control port
  input wire logic ctrl_select_n,
  input wire logic ctrl_read_strobe_n,
  input wire logic ctrl_write_strobe_n,
  input wire logic [pbtdm_pkg::IDX_W-1:0] ctrl_index,
  input wire logic [pbtdm_pkg::DATA_W-1:0] ctrl_wdata,
  output logic [pbtdm_pkg::DATA_W-1:0] ctrl_rdata,
  output logic ctrl_rdata_oe_n
);
  import pbtdm_pkg::*;

  localparam int CNT_W = $clog2(TIMEOUT_CYC + 1);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(TIMEOUT_CYC - 1);
  localparam logic [CNT_W-1:0] CNT_ZERO = '0;

  pbtdm_tstate_t tstate_ff, nxt_tstate;
  pbtdm_mstate_t mstate_ff, nxt_mstate;
  logic [CNT_W-1:0] wait_ff;
  logic devsel_n_ff, trdy_n_ff, stop_n_ff, tgt_oe_n_ff;
  logic grant_ff, int_smp_ff, inta_oe_n_ff;
  logic req_n_ff, frame_n_ff, irdy_n_ff, mst_oe_n_ff, dps_ff;
  logic [DATA_W-1:0] ad_ff, waddr_ff, raddr_ff, wdata_ff;
  logic ad_oe_n_ff, cbe_oe_n_ff, rd_stb_ff, wr_stb_ff, dir_wr_ff;
  logic [3:0] cbe_ff;
  logic [LEN_W-1:0] xfer_left_ff, fetch_left_ff;
  logic [DATA_W-1:0] pipe_ff [2];
  logic rdp_ff, wrp_ff, primed_ff;
  logic [FILL_W-1:0] fill_ff;
  logic done_set;
  logic [DATA_W-1:0] pci_start, ram_start, control;
  logic go;

  // ----------------------------------------------------------------------
  // DMA registers
  // ----------------------------------------------------------------------
  pbtdm_dma_regs u_regs (
    .clock(clock),
    .resetn(resetn),
    .ctrl_select_n(ctrl_select_n),
    .ctrl_read_strobe_n(ctrl_read_strobe_n),
    .ctrl_write_strobe_n(ctrl_write_strobe_n),
    .ctrl_index(ctrl_index),
    .ctrl_wdata(ctrl_wdata),
    .ctrl_rdata(ctrl_rdata),
    .ctrl_rdata_oe_n(ctrl_rdata_oe_n),
    .done_set(done_set),
    .pci_start_addr(pci_start),
    .ram_start_addr(ram_start),
    .control(control),
    .go(go)
  );

  // ----------------------------------------------------------------------
  // Target termination
  // ----------------------------------------------------------------------
  wire be_ready = access_is_read ? backend_read_ready : backend_write_ready;
  wire timed_out = (wait_ff == CNT_LAST) || backend_busy;
  wire bus_end = frame_n_in && !irdy_n_in;
  wire bus_idle = frame_n_in && irdy_n_in;

  always_comb begin
    nxt_tstate = tstate_ff;
    unique case (tstate_ff)
      T_IDLE: if (access_start) begin
        nxt_tstate = (grant_ff || backend_busy) ? T_RETRY : T_DATA;
      end
      T_DATA: begin
        if (backend_error) nxt_tstate = T_ABORT;
        else if (!be_ready && timed_out) nxt_tstate = T_DISC;
        else if (bus_end && !trdy_n_ff) nxt_tstate = T_IDLE;
      end
      T_RETRY, T_ABORT, T_DISC: if (bus_idle) nxt_tstate = T_IDLE;
    endcase
  end

  wire tgt_busy = (nxt_tstate != T_IDLE);
  wire nxt_devsel_n = !(nxt_tstate == T_DATA || nxt_tstate == T_RETRY
    || nxt_tstate == T_DISC);
  wire nxt_stop_n = !(nxt_tstate == T_RETRY || nxt_tstate == T_ABORT
    || nxt_tstate == T_DISC);
  wire nxt_trdy_n = !(nxt_tstate == T_DATA && be_ready
    && !backend_error);
  wire [CNT_W-1:0] nxt_wait = (nxt_tstate == T_DATA && !be_ready)
    ? wait_ff + CNT_W'(1) : CNT_ZERO;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      tstate_ff <= T_IDLE;
      wait_ff <= CNT_ZERO;
      devsel_n_ff <= 1'b1;
      stop_n_ff <= 1'b1;
      trdy_n_ff <= 1'b1;
      tgt_oe_n_ff <= 1'b1;
    end else begin
      tstate_ff <= nxt_tstate;
      wait_ff <= nxt_wait;
      devsel_n_ff <= nxt_devsel_n;
      stop_n_ff <= nxt_stop_n;
      trdy_n_ff <= nxt_trdy_n;
      tgt_oe_n_ff <= !(tgt_busy || tstate_ff != T_IDLE);
    end
  end

  // ----------------------------------------------------------------------
  // Backend arbitration and interrupt
  // ----------------------------------------------------------------------
  wire ctl_idle = (tstate_ff == T_IDLE) && (mstate_ff == M_IDLE);
  wire nxt_grant = backend_request
    && (grant_ff || (ctl_idle && !access_start));

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      grant_ff <= 1'b0;
      int_smp_ff <= 1'b1;
      inta_oe_n_ff <= 1'b1;
    end else begin
      grant_ff <= nxt_grant;
      int_smp_ff <= external_interrupt_in;
      inta_oe_n_ff <= int_smp_ff;
    end
  end

  // ----------------------------------------------------------------------
  // DMA master sequencing
  // ----------------------------------------------------------------------
  wire [LEN_W-1:0] len_raw = LEN_W'(control[CTL_LEN_MSB:CTL_LEN_LSB]);
  wire len_zero = (control[CTL_LEN_MSB:CTL_LEN_LSB] == '0);
  wire [LEN_W-1:0] len_load = len_zero ? LEN_MAX : len_raw;
  wire xfer = (mstate_ff == M_DATA) && !irdy_n_ff && !trdy_n_in;
  wire tgt_stop = (mstate_ff == M_DATA) && !stop_n_in;
  wire [LEN_W-1:0] nxt_xfer_left = go ? len_load
    : (xfer ? xfer_left_ff - LEN_ONE : xfer_left_ff);
  wire last_done = frame_n_ff && !irdy_n_ff && (!trdy_n_in || !stop_n_in);

  always_comb begin
    nxt_mstate = mstate_ff;
    unique case (mstate_ff)
      M_IDLE: if (go) nxt_mstate = M_REQ;
      M_REQ: if (!gnt_n && bus_idle && !tgt_busy) nxt_mstate = M_ADDR;
      M_ADDR: nxt_mstate = M_DATA;
      M_DATA: if (last_done) nxt_mstate = M_TURN;
      M_TURN: begin
        if (xfer_left_ff != LEN_ZERO) nxt_mstate = M_REQ;
        else if (fill_ff == FILL_ZERO && !wr_stb_ff) nxt_mstate = M_IDLE;
      end
    endcase
  end

  assign done_set = (mstate_ff == M_TURN) && (nxt_mstate == M_IDLE);

  // ----------------------------------------------------------------------
  // Two-entry datapath pipe
  // ----------------------------------------------------------------------
  wire push = dir_wr_ff ? rd_stb_ff : (xfer && !dir_wr_ff);
  wire [DATA_W-1:0] push_data = dir_wr_ff ? backend_rdata : ad_in;
  wire nxt_wr_stb = !dir_wr_ff && (fill_ff != FILL_ZERO)
    && backend_write_ready;
  wire pop = dir_wr_ff ? xfer : nxt_wr_stb;
  wire [FILL_W-1:0] fill_next = fill_ff + FILL_W'(push) - FILL_W'(pop);
  wire nxt_rdp = rdp_ff ^ pop;
  wire [DATA_W-1:0] nxt_head = (push && wrp_ff == nxt_rdp) ? push_data
    : pipe_ff[nxt_rdp];
  wire in_burst = (mstate_ff == M_ADDR) || (mstate_ff == M_DATA);
  wire nxt_rd_stb = dir_wr_ff && in_burst && backend_read_ready
    && (fill_next < PIPE_DEPTH) && (fetch_left_ff > LEN_ONE
    || (fetch_left_ff == LEN_ONE && !rd_stb_ff));

  // ----------------------------------------------------------------------
  // Master control outputs
  // ----------------------------------------------------------------------
  wire [LEN_W-1:0] fetch_next = go ? len_load
    : (nxt_rd_stb ? fetch_left_ff - LEN_ONE : fetch_left_ff);
  wire pipe_ready = primed_ff || (fill_next == PIPE_DEPTH)
    || (LEN_W'(fill_next) >= nxt_xfer_left);
  wire nxt_irdy_req = dir_wr_ff ? (fill_next != FILL_ZERO && pipe_ready)
    : (fill_next < PIPE_DEPTH && backend_write_ready);
  wire enter_data = (mstate_ff == M_ADDR)
    || (mstate_ff == M_DATA && !last_done);
  wire nxt_irdy_n = !(enter_data && (nxt_irdy_req || frame_n_ff
    || tgt_stop || !irdy_n_ff && trdy_n_in && stop_n_in));
  wire nxt_frame_n = !((nxt_mstate == M_ADDR) || (enter_data
    && !frame_n_ff && !tgt_stop && !(xfer && nxt_xfer_left == LEN_ZERO)
    && !(!nxt_irdy_n && nxt_xfer_left == LEN_ONE)));
  wire nxt_mst_oe_n = !(nxt_mstate == M_ADDR || nxt_mstate == M_DATA
    || nxt_mstate == M_TURN);
  wire [3:0] nxt_cbe = (nxt_mstate == M_ADDR)
    ? (control[CTL_DIR_BIT] ? CMD_MEM_WRITE : CMD_MEM_READ)
    : BE_ALL_N;
  wire [DATA_W-1:0] nxt_ad = (nxt_mstate == M_ADDR) ? waddr_ff : nxt_head;
  wire nxt_ad_oe_n = !((nxt_mstate == M_ADDR)
    || (nxt_mstate == M_DATA && dir_wr_ff));
  wire [DATA_W-1:0] nxt_waddr = go ? pci_start
    : (xfer ? waddr_ff + ADDR_STEP : waddr_ff);
  wire be_step = rd_stb_ff || wr_stb_ff;
  wire [DATA_W-1:0] nxt_raddr = go ? ram_start
    : (be_step ? raddr_ff + ADDR_STEP : raddr_ff);

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      mstate_ff <= M_IDLE;
      req_n_ff <= 1'b1;
      frame_n_ff <= 1'b1;
      irdy_n_ff <= 1'b1;
      mst_oe_n_ff <= 1'b1;
      dps_ff <= 1'b0;
      cbe_ff <= BE_ALL_N;
      cbe_oe_n_ff <= 1'b1;
      ad_ff <= DATA_ZERO;
      ad_oe_n_ff <= 1'b1;
      dir_wr_ff <= 1'b0;
      xfer_left_ff <= LEN_ZERO;
      fetch_left_ff <= LEN_ZERO;
      waddr_ff <= ADDR_RESET;
      raddr_ff <= ADDR_RESET;
      primed_ff <= 1'b0;
    end else begin
      mstate_ff <= nxt_mstate;
      req_n_ff <= !(nxt_mstate == M_REQ);
      frame_n_ff <= nxt_frame_n;
      irdy_n_ff <= nxt_irdy_n;
      mst_oe_n_ff <= nxt_mst_oe_n;
      dps_ff <= (mstate_ff == M_REQ) && (nxt_mstate == M_ADDR);
      cbe_ff <= nxt_cbe;
      cbe_oe_n_ff <= nxt_ad_oe_n && (nxt_mstate != M_DATA);
      ad_ff <= nxt_ad;
      ad_oe_n_ff <= nxt_ad_oe_n;
      if (go) dir_wr_ff <= control[CTL_DIR_BIT];
      xfer_left_ff <= nxt_xfer_left;
      fetch_left_ff <= fetch_next;
      waddr_ff <= nxt_waddr;
      raddr_ff <= nxt_raddr;
      primed_ff <= enter_data && (primed_ff || !nxt_irdy_n);
    end
  end

  // ----------------------------------------------------------------------
  // Pipe storage and backend strobes
  // ----------------------------------------------------------------------
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pipe_ff[0] <= DATA_ZERO;
      pipe_ff[1] <= DATA_ZERO;
      rdp_ff <= 1'b0;
      wrp_ff <= 1'b0;
      fill_ff <= FILL_ZERO;
      rd_stb_ff <= 1'b0;
      wr_stb_ff <= 1'b0;
      wdata_ff <= DATA_ZERO;
    end else begin
      if (push) pipe_ff[wrp_ff] <= push_data;
      if (push) wrp_ff <= !wrp_ff;
      rdp_ff <= nxt_rdp;
      fill_ff <= fill_next;
      rd_stb_ff <= nxt_rd_stb;
      wr_stb_ff <= nxt_wr_stb;
      if (nxt_wr_stb) wdata_ff <= pipe_ff[rdp_ff];
    end
  end

  // ----------------------------------------------------------------------
  // Output wiring
  // ----------------------------------------------------------------------
  assign devsel_n_out = devsel_n_ff;
  assign trdy_n_out = trdy_n_ff;
  assign stop_n_out = stop_n_ff;
  assign tgt_ctl_oe_n = tgt_oe_n_ff;
  assign backend_grant = grant_ff;
  assign inta_n_out = 1'b0;
  assign inta_n_oe_n = inta_oe_n_ff;
  assign req_n = req_n_ff;
  assign frame_n_out = frame_n_ff;
  assign irdy_n_out = irdy_n_ff;
  assign mst_ctl_oe_n = mst_oe_n_ff;
  assign datapath_start = dps_ff;
  assign ad_out = ad_ff;
  assign ad_oe_n = ad_oe_n_ff;
  assign cbe_n_out = cbe_ff;
  assign cbe_n_oe_n = cbe_oe_n_ff;
  assign backend_read_strobe = rd_stb_ff;
  assign backend_write_strobe = wr_stb_ff;
  assign backend_wdata = wdata_ff;
  assign backend_addr = raddr_ff;

endmodule : pbtdm_top
`default_nettype wire

// ==== test/pbtdm_far_model.sv ====
// Purpose: PCI target, arbiter and backend memory model
// Assumes: Grant follows request after one edge
// Notes: Undriven data shows the inverse word
`timescale 1ns/1ps
`default_nettype none
module pbtdm_far_model (
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // PCI levels
  input wire logic req_n,
  input wire logic frame_n_in,
  input wire logic irdy_n_in,
  output logic gnt_n,
  output logic far_trdy_n,
  output logic [31:0] ad_far,
  // Backend memory
  input wire logic backend_read_strobe,
  input wire logic [31:0] backend_addr,
  output logic [31:0] backend_rdata
);
  logic act_ff;
  logic [31:0] beat_ff;
  wire logic [31:0] word = 32'hA5A5_0000 + beat_ff;
  wire logic [31:0] mem = backend_addr ^ 32'h5A5A_0000;
  assign ad_far = far_trdy_n ? ~word : word;
  assign backend_rdata = backend_read_strobe ? mem : ~mem;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      gnt_n <= 1'b1;
      far_trdy_n <= 1'b1;
      act_ff <= 1'b0;
      beat_ff <= '0;
    end else begin
      gnt_n <= req_n;
      if (!frame_n_in && irdy_n_in) act_ff <= 1'b1;
      else if (frame_n_in && irdy_n_in) act_ff <= 1'b0;
      far_trdy_n <= !(act_ff && !irdy_n_in);
      if (!far_trdy_n && !irdy_n_in) beat_ff <= beat_ff + 32'h0000_0001;
      else if (frame_n_in && irdy_n_in) beat_ff <= '0;
    end
  end
endmodule : pbtdm_far_model
`default_nettype wire

// ==== test/pbtdm_top_asserts.sv ====
// Purpose: Port checker for pbtdm_top
// Assumes: One clock, async active-low reset
// Notes: Bound into every pbtdm_top
`timescale 1ns/1ps
`default_nettype none
module pbtdm_chk (
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Target side
  input wire logic access_start,
  input wire logic backend_error,
  input wire logic backend_busy,
  input wire logic devsel_n_out,
  input wire logic trdy_n_out,
  input wire logic stop_n_out,
  input wire logic tgt_ctl_oe_n,
  // Arbitration and interrupt
  input wire logic backend_request,
  input wire logic backend_grant,
  input wire logic external_interrupt_in,
  input wire logic inta_n_oe_n,
  // Master side
  input wire logic backend_write_ready,
  input wire logic datapath_start,
  input wire logic frame_n_out,
  input wire logic irdy_n_out,
  input wire logic mst_ctl_oe_n,
  input wire logic [3:0] cbe_n_out,
  // Control port
  input wire logic ctrl_select_n,
  input wire logic ctrl_read_strobe_n,
  input wire logic ctrl_rdata_oe_n
);
  import pbtdm_pkg::*;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  sequence s_int_lag;
    inta_n_oe_n ##1 !inta_n_oe_n;
  endsequence
  a_abort_shape: assert property (backend_error && !tgt_ctl_oe_n
    |=> !stop_n_out && devsel_n_out) else $error("abort shape");
  a_retry_shape: assert property (access_start
    && (backend_grant || backend_busy)
    |=> !stop_n_out && !devsel_n_out && trdy_n_out) else $error("retry");
  a_stop_no_trdy: assert property (!tgt_ctl_oe_n
    && !stop_n_out && !devsel_n_out |-> trdy_n_out) else $error("trdy");
  a_grant_hold: assert property (backend_grant
    |=> backend_grant == $past(backend_request)) else $error("grant");
  a_int_lag: assert property ($fell(external_interrupt_in)
    && inta_n_oe_n |=> s_int_lag) else $error("interrupt lag");
  a_start_frame: assert property (datapath_start
    |-> !frame_n_out && $past(frame_n_out) && !mst_ctl_oe_n
    && (cbe_n_out == CMD_MEM_READ || cbe_n_out == CMD_MEM_WRITE))
    else $error("address phase");
  a_irdy_next: assert property (datapath_start
    && cbe_n_out == CMD_MEM_READ && backend_write_ready
    |=> !irdy_n_out) else $error("irdy late");
  a_frame_last: assert property ($rose(frame_n_out)
    && !mst_ctl_oe_n |-> !irdy_n_out) else $error("frame end");
  a_rdata_drive: assert property (1'b1
    |=> ctrl_rdata_oe_n == $past(ctrl_select_n || ctrl_read_strobe_n))
    else $error("read drive");
endmodule : pbtdm_chk
bind pbtdm_top pbtdm_chk chk (.*);
`default_nettype wire

// ==== test/pbtdm_top_test.sv ====
// Purpose: Self-checking bench for pbtdm_top
// Assumes: Inputs change at the falling edge
// Notes: Disconnect time-out shortened to TO
`timescale 1ns/1ps
`default_nettype none
module pbtdm_top_test;
  import pbtdm_pkg::*;
  localparam int TO = 2;
  localparam logic [31:0] ZERO = 32'h0000_0000;
  localparam logic [31:0] ONE = 32'h0000_0001;
  localparam logic [31:0] PA = 32'h1000_0000;
  localparam logic [31:0] RA = 32'h0000_0100;
  logic clock = 1'b0, resetn = 1'b0, access_start = 1'b0;
  logic access_is_read = 1'b1, backend_error = 1'b0, backend_busy = 1'b0;
  logic backend_read_ready = 1'b1, backend_write_ready = 1'b1;
  logic tb_frame_n = 1'b1, tb_irdy_n = 1'b1, backend_request = 1'b0;
  logic external_interrupt_in = 1'b1, ctrl_select_n = 1'b1;
  logic ctrl_read_strobe_n = 1'b1, ctrl_write_strobe_n = 1'b1;
  logic [1:0] ctrl_index = 2'h0;
  logic [31:0] ctrl_wdata = ZERO;
  logic devsel_n_out, trdy_n_out, stop_n_out, tgt_ctl_oe_n, backend_grant;
  logic inta_n_out, inta_n_oe_n, req_n, frame_n_out, irdy_n_out, gnt_n;
  logic mst_ctl_oe_n, datapath_start, ad_oe_n, cbe_n_oe_n, far_trdy_n;
  logic backend_read_strobe, backend_write_strobe, ctrl_rdata_oe_n;
  logic [31:0] ad_out, backend_wdata, backend_addr, ctrl_rdata, ad_far;
  logic [31:0] backend_rdata, w0, a0, v;
  logic [3:0] cbe_n_out;
  logic [11:0] lens [3] = '{12'h003, 12'h002, 12'h000};
  int err_count = 0, checks_done = 0, n, wcnt;
  wire logic stop_n_in = 1'b1;
  wire logic frame_n_in = mst_ctl_oe_n ? tb_frame_n : frame_n_out;
  wire logic irdy_n_in = mst_ctl_oe_n ? tb_irdy_n : irdy_n_out;
  wire logic trdy_n_in = tgt_ctl_oe_n ? far_trdy_n : trdy_n_out;
  wire logic [31:0] ad_in = ad_oe_n ? ad_far : ad_out;
  wire logic [31:0] tsd = {29'h0000_0000, stop_n_out, devsel_n_out,
    trdy_n_out};
  pbtdm_top #(.TIMEOUT_CYC(TO)) dut (.*);
  pbtdm_far_model far (.*);
  always #20 clock = ~clock;
  always @(posedge clock) begin
    if (backend_write_strobe === 1'b1) begin
      if (wcnt == 0) {w0, a0} = {backend_wdata, backend_addr};
      wcnt++;
    end
  end
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  function automatic logic [31:0] b(input logic x);
    return {31'h0000_0000, x};
  endfunction : b
  task automatic rd(input logic [1:0] i, output logic [31:0] d);
    @(negedge clock);
    ctrl_index = i;
    ctrl_select_n = 1'b0;
    ctrl_read_strobe_n = 1'b0;
    repeat (2) @(negedge clock);
    d = ctrl_rdata;
    ctrl_select_n = 1'b1;
    ctrl_read_strobe_n = 1'b1;
  endtask : rd
  task automatic wr(input logic [1:0] i, input logic [31:0] d);
    @(negedge clock);
    ctrl_index = i;
    ctrl_wdata = d;
    ctrl_select_n = 1'b0;
    ctrl_write_strobe_n = 1'b0;
  endtask : wr
  task automatic wend;
    @(negedge clock);
    ctrl_select_n = 1'b1;
    ctrl_write_strobe_n = 1'b1;
  endtask : wend
  task automatic start;
    @(negedge clock);
    access_start = 1'b1;
    tb_frame_n = 1'b0;
    tb_irdy_n = 1'b0;
    @(negedge clock);
    access_start = 1'b0;
  endtask : start
  task automatic term;
    @(negedge clock);
    tb_frame_n = 1'b1;
    @(negedge clock);
    tb_irdy_n = 1'b1;
    for (n = 0; n < 20 && tgt_ctl_oe_n !== 1'b1; n++) @(negedge clock);
    cmp(b(tgt_ctl_oe_n), ONE);
  endtask : term
  task automatic conclude;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : conclude
  initial begin
    #(40 * 30000);
    err_count++;
    conclude();
  end
  initial begin
    repeat (12) @(negedge clock);
    resetn = 1'b1;
    cmp(b(backend_grant), ZERO);
    cmp(b(inta_n_oe_n), ONE);
    rd(IDX_CONTROL, v);
    cmp(v, CTL_RESET);
    wr(IDX_PCI_ADDR, PA);
    wr(IDX_RAM_ADDR, RA);
    wr(2'h3, 32'hFFFF_FFFF);
    wend();
    rd(IDX_PCI_ADDR, v);
    cmp(v, PA);
    rd(IDX_RAM_ADDR, v);
    cmp(v, RA);
    rd(2'h3, v);
    cmp(v, ZERO);
    $display("test registers done");
    backend_request = 1'b1;
    @(negedge clock);
    cmp(b(backend_grant), ONE);
    start();
    cmp(tsd, ONE);
    term();
    backend_request = 1'b0;
    @(negedge clock);
    cmp(b(backend_grant), ZERO);
    backend_busy = 1'b1;
    start();
    backend_busy = 1'b0;
    cmp(tsd, ONE);
    term();
    start();
    backend_error = 1'b1;
    backend_read_ready = 1'b0;
    @(negedge clock);
    cmp(tsd, 32'h0000_0003);
    backend_error = 1'b0;
    term();
    backend_read_ready = 1'b1;
    start();
    @(negedge clock);
    cmp(b(trdy_n_out), ZERO);
    backend_read_ready = 1'b0;
    @(negedge clock);
    cmp(b(trdy_n_out), ONE);
    backend_busy = 1'b1;
    for (n = 0; n < TO + 4 && stop_n_out !== 1'b0; n++) @(negedge clock);
    cmp(tsd, ONE);
    term();
    backend_busy = 1'b0;
    backend_read_ready = 1'b1;
    $display("test termination done");
    external_interrupt_in = 1'b0;
    @(negedge clock);
    cmp(b(inta_n_oe_n), ONE);
    @(negedge clock);
    cmp(b(inta_n_oe_n), ZERO);
    external_interrupt_in = 1'b1;
    $display("test interrupt done");
    for (int k = 0; k < 3; k++) begin
      wcnt = 0;
      wr(IDX_PCI_ADDR, PA);
      wr(IDX_RAM_ADDR, RA);
      wr(IDX_CONTROL, {4'h0, lens[k], 8'h00, 2'h0, 2'h3, k[0], 3'h0});
      wend();
      for (n = 0; n < 100 && datapath_start !== 1'b1; n++) @(negedge clock);
      cmp(ad_out, PA);
      cmp(32'(cbe_n_out), k[0] ? 32'h0000_0007 : 32'h0000_0006);
      v = ZERO;
      for (n = 0; n < 3000 && v[CTL_DONE_BIT] !== 1'b1; n++) rd(IDX_CONTROL, v);
      cmp(b(v[CTL_DONE_BIT]), ONE);
      rd(IDX_CONTROL, v);
      cmp(b(v[CTL_DONE_BIT]), ONE);
      if (!k[0]) begin
        cmp(32'(wcnt), (lens[k] == 12'h000) ? 32'h0000_0400 : 32'(lens[k]));
        cmp(w0, 32'hA5A5_0000);
        cmp(a0, RA);
      end
      $display("test dma %0d done", k);
    end
    conclude();
  end
endmodule : pbtdm_top_test
`default_nettype wire
